// ==== hdl/lsa_alert_unit.sv ====
// Limit status, alert masking, alert pin routing and thermal boost logic
//
// Functional notes
// - Status bit sets when the latest channel comparison is out of limits.
// - Status bits are sticky; clear only on read once the condition has gone.
// - Primary bit 7 is set whenever any secondary status bit is set.
// - Primary bits 6..0: remote2, local, remote1, 5V, supply, core, 2.5V.
// - Secondary bits 7 and 6: second and first diode open or short.
// - Secondary bit 5: fan four slow, or cumulative thermal limit if in use.
// - Secondary bits 4, 3, 2: fans three, two, one below minimum speed.
// - Secondary bit 1: any temperature over its thermal limit.
// - Secondary bit 0: 12V limit, or voltage-ID code change when selected.
// - Mask only gates the alert; status still sets.
// - Mask registers mirror status layout; a 1 masks that source.
// - Primary mask bit 7 masks every secondary source.
// - Secondary mask bit 0 masks whichever function bit 0 carries.
// - Alert stays low while unmasked reading out of limit, then until read.
// - Alert disabled after reset; two independent config bits route it to either pin or to both.
// - Thermal function needs enable; select bit picks exactly one pin.
// - With boost set, fans run full duty while thermal pin held low.
// - Boost affects only fans already running.
// - High violation when value above limit; low when at or below.
`timescale 1ns/10ps

module lsa_alert_unit #(
  parameter int vid_width = lsa_pkg::vid_width,
  parameter int fan_count = lsa_pkg::fan_count
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Register port from the serial interface
  input  wire lsa_pkg::lsa_reg_req_t    reg_req,
  output logic [7:0]                    reg_rdata,
  // Comparison results, one strobe per finished conversion
  input  wire lsa_pkg::lsa_sources_t    result_valid,
  input  wire lsa_pkg::lsa_sources_t    result_high,
  input  wire lsa_pkg::lsa_sources_t    result_low,
  input  wire logic                     thermal_limit_exceeded,
  input  wire logic [vid_width-1:0]     voltage_id_input,
  input  wire logic                     id_change_select,
  // Pins
  input  wire logic                     thermal_pin_a_in,
  input  wire logic                     thermal_pin_b_in,
  output logic                          alert_pin_a_n,
  output logic                          alert_pin_a_oe,
  output logic                          alert_pin_b_n,
  output logic                          alert_pin_b_oe,
  // Fan boost
  input  wire logic [fan_count-1:0]     fan_running,
  output logic [fan_count-1:0]          fan_full_duty,
  output logic                          thermal_event_pin
);

  // ==========================================================================
  // Register storage
  logic [7:0] primary_limit_status;
  logic [7:0] secondary_limit_status;
  logic [7:0] primary_alert_mask;
  logic [7:0] secondary_alert_mask;
  logic [7:0] config_three;
  logic [7:0] config_four;

  logic wr_hit_mask1;
  logic wr_hit_mask2;
  logic rd_primary;
  logic rd_secondary;

  assign wr_hit_mask1 = reg_req.write &&
                        reg_req.addr == lsa_pkg::primary_alert_mask_addr;
  assign wr_hit_mask2 = reg_req.write &&
                        reg_req.addr == lsa_pkg::secondary_alert_mask_addr;
  assign rd_primary   = reg_req.read &&
                        reg_req.addr == lsa_pkg::primary_limit_status_addr;
  assign rd_secondary = reg_req.read &&
                        reg_req.addr == lsa_pkg::secondary_limit_status_addr;

  // ==========================================================================
  // Thermal pin synchronisers, three stages each
  logic [2:0] thermal_event_pin_a_sync;
  logic [2:0] thermal_event_pin_b_sync;
  logic       thermal_event_pin_a_low;
  logic       thermal_event_pin_b_low;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      thermal_event_pin_a_sync <= 3'h7;
      thermal_event_pin_b_sync <= 3'h7;
      thermal_event_pin_a_low  <= 1'b0;
      thermal_event_pin_b_low  <= 1'b0;
    end else begin
      thermal_event_pin_a_sync <= {thermal_event_pin_a_sync[1:0], thermal_pin_a_in};
      thermal_event_pin_b_sync <= {thermal_event_pin_b_sync[1:0], thermal_pin_b_in};
      // A change counts once the second and third stages agree
      if (thermal_event_pin_a_sync[1] == thermal_event_pin_a_sync[2]) begin
        thermal_event_pin_a_low <= ~thermal_event_pin_a_sync[2];
      end
      if (thermal_event_pin_b_sync[1] == thermal_event_pin_b_sync[2]) begin
        thermal_event_pin_b_low <= ~thermal_event_pin_b_sync[2];
      end
    end
  end

  logic thermal_enabled;
  logic thermal_asserted;

  assign thermal_enabled = config_three[lsa_pkg::thermal_enable_bit];
  // Only the selected pin is looked at, never both
  assign thermal_asserted = thermal_enabled &&
      (config_four[lsa_pkg::thermal_pin_select_bit] ?
       thermal_event_pin_b_low : thermal_event_pin_a_low);
  assign thermal_event_pin = thermal_asserted;

  // ==========================================================================
  // Voltage-ID change detection
  logic [vid_width-1:0] vid_last;
  logic                 vid_changed;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vid_last <= '0;
    end else begin
      vid_last <= voltage_id_input;
    end
  end

  assign vid_changed = (vid_last != voltage_id_input);

  // ==========================================================================
  // Live out-of-limit condition per status bit
  // Comparator feeds give the >-high and <=-low verdicts already
  logic [7:0] primary_live;
  logic [7:0] secondary_live;
  logic [7:0] primary_event;
  logic [7:0] secondary_event;

  // Live state follows the last comparison of each channel
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      primary_live   <= 8'h00;
      secondary_live <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (result_valid.primary[i]) begin
          primary_live[i] <= result_high.primary[i] |
                             result_low.primary[i];
        end
        if (result_valid.secondary[i]) begin
          secondary_live[i] <= result_high.secondary[i] |
                               result_low.secondary[i];
        end
      end
      if (thermal_enabled) begin
        secondary_live[lsa_pkg::fan_four_bit] <= thermal_limit_exceeded;
      end
      if (id_change_select) begin
        secondary_live[lsa_pkg::id_change_bit] <= vid_changed;
      end
    end
  end

  always_comb begin
    primary_event   = primary_live;
    secondary_event = secondary_live;
    primary_event[lsa_pkg::secondary_pending_bit] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (result_valid.primary[i] && i != lsa_pkg::secondary_pending_bit) begin
        primary_event[i] = result_high.primary[i] | result_low.primary[i];
      end
      if (result_valid.secondary[i]) begin
        secondary_event[i] = result_high.secondary[i] |
                             result_low.secondary[i];
      end
    end
    if (thermal_enabled) begin
      secondary_event[lsa_pkg::fan_four_bit] = thermal_limit_exceeded;
    end
    if (id_change_select) begin
      secondary_event[lsa_pkg::id_change_bit] = vid_changed;
    end
  end

  // ==========================================================================
  // Sticky status: set wins over read-clear; clear only where condition gone
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      secondary_limit_status <= lsa_pkg::status_reset;
    end else if (rd_secondary) begin
      secondary_limit_status <= secondary_event;
    end else begin
      secondary_limit_status <= secondary_limit_status |
                                secondary_event;
    end
  end

  logic [6:0] primary_low;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      primary_low <= 7'h00;
    end else if (rd_primary) begin
      primary_low <= primary_event[6:0];
    end else begin
      primary_low <= primary_low | primary_event[6:0];
    end
  end

  // Summary bit tracks the secondary register directly
  assign primary_limit_status = {(|secondary_limit_status), primary_low};

  // ==========================================================================
  // Mask and configuration registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      primary_alert_mask   <= lsa_pkg::mask_reset;
      secondary_alert_mask <= lsa_pkg::mask_reset;
    end else begin
      if (wr_hit_mask1) begin
        primary_alert_mask <= reg_req.wdata;
      end
      if (wr_hit_mask2) begin
        secondary_alert_mask <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      config_three <= lsa_pkg::config_reset;
      config_four  <= lsa_pkg::config_reset;
    end else begin
      if (reg_req.write && reg_req.addr == lsa_pkg::config_three_addr) begin
        config_three <= reg_req.wdata;
      end
      if (reg_req.write && reg_req.addr == lsa_pkg::config_four_addr) begin
        config_four <= reg_req.wdata;
      end
    end
  end

  // ==========================================================================
  // Read data, registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.read) begin
      unique case (reg_req.addr)
        lsa_pkg::primary_limit_status_addr:   reg_rdata <= primary_limit_status;
        lsa_pkg::secondary_limit_status_addr: reg_rdata <= secondary_limit_status;
        lsa_pkg::primary_alert_mask_addr:     reg_rdata <= primary_alert_mask;
        lsa_pkg::secondary_alert_mask_addr:   reg_rdata <= secondary_alert_mask;
        lsa_pkg::config_three_addr:           reg_rdata <= config_three;
        lsa_pkg::config_four_addr:            reg_rdata <= config_four;
        default:                              reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Alert combination
  logic alert_cause;
  logic secondary_cause;

  // Bit 0 mask applies to whichever function bit 0 is carrying
  assign secondary_cause = |(secondary_limit_status &
                             ~secondary_alert_mask);
  assign alert_cause = (|(primary_low & ~primary_alert_mask[6:0])) |
      (secondary_cause &
       ~primary_alert_mask[lsa_pkg::secondary_pending_bit]);

  // Open-drain style: drive low only while an alert is due
  logic route_a;
  logic route_b;

  assign route_a = config_three[lsa_pkg::alert_enable_bit];
  assign route_b = config_four[lsa_pkg::alert_on_alternate_bit];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alert_pin_a_oe <= 1'b0;
      alert_pin_b_oe <= 1'b0;
    end else begin
      alert_pin_a_oe <= route_a & alert_cause;
      alert_pin_b_oe <= route_b & alert_cause;
    end
  end

  assign alert_pin_a_n = 1'b0;
  assign alert_pin_b_n = 1'b0;

  // ==========================================================================
  // Fan boost on external thermal assertion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fan_full_duty <= '0;
    end else begin
      for (int f = 0; f < fan_count; f++) begin
        fan_full_duty[f] <= config_three[lsa_pkg::boost_bit] &&
                            thermal_asserted && fan_running[f];
      end
    end
  end

endmodule : lsa_alert_unit

// ==== hdl/lsa_pkg.sv ====
// Package: register map, field positions and carrier types for the alert unit
package lsa_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] primary_limit_status_addr   = 8'h41;
  localparam logic [7:0] secondary_limit_status_addr = 8'h42;
  localparam logic [7:0] primary_alert_mask_addr     = 8'h74;
  localparam logic [7:0] secondary_alert_mask_addr   = 8'h75;
  localparam logic [7:0] config_three_addr           = 8'h78;
  localparam logic [7:0] config_four_addr            = 8'h7d;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] mask_reset   = 8'h00;
  localparam logic [7:0] config_reset = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int secondary_pending_bit = 7;
  localparam int fan_four_bit          = 5;
  localparam int id_change_bit         = 0;
  localparam int alert_enable_bit      = 0;
  localparam int thermal_enable_bit    = 1;
  localparam int boost_bit             = 2;
  localparam int alert_on_alternate_bit = 0;
  localparam int thermal_pin_select_bit = 1;
  localparam int fan_count             = 4;
  localparam int vid_width             = 6;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsa_reg_req_t;

  // Per-source comparison results, one bit per status position
  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] secondary;
  } lsa_sources_t;

endpackage : lsa_pkg

// ==== test/lsa_alert_unit_sva.sv ====
// Checker: assertions on the alert unit ports
`timescale 1ns/10ps
module lsa_alert_unit_sva #(
  parameter int fan_count = 4
) (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire lsa_pkg::lsa_reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  input wire lsa_pkg::lsa_sources_t result_valid,
  input wire lsa_pkg::lsa_sources_t result_high,
  input wire lsa_pkg::lsa_sources_t result_low,
  input wire logic                  alert_pin_a_n,
  input wire logic                  alert_pin_a_oe,
  input wire logic                  alert_pin_b_n,
  input wire logic                  alert_pin_b_oe,
  input wire logic [fan_count-1:0]  fan_running,
  input wire logic [fan_count-1:0]  fan_full_duty,
  input wire logic                  thermal_event_pin
);
  // ==========================================================================
  // Shadows of control registers and of flags known to be pending
  logic [7:0] cfg3, cfg4, m1;
  logic [6:0] pri_pend;
  logic       sec_pend;
  wire        rd41 = reg_req.read && reg_req.addr == 8'h41;
  wire [15:0] outs = result_valid & (result_high | result_low);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg3 <= 8'h00;
      cfg4 <= 8'h00;
      m1   <= 8'h00;
    end else if (reg_req.write) begin
      if (reg_req.addr == 8'h78) cfg3 <= reg_req.wdata;
      if (reg_req.addr == 8'h7d) cfg4 <= reg_req.wdata;
      if (reg_req.addr == 8'h74) m1 <= reg_req.wdata;
    end
  end
  // Pending sets are a subset of the true status except while the thermal or ID-change function drives secondary bit 5 or 0
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pri_pend <= 7'h00;
      sec_pend <= 1'b0;
    end else begin
      pri_pend <= rd41 ? 7'h00 : pri_pend | outs[14:8];
      sec_pend <= (reg_req.read && reg_req.addr == 8'h42) ? 1'b0
                  : sec_pend | (|outs[7:0]);
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_pri_read;
    rd41;
  endsequence
  sequence s_summary_read;
    rd41 && sec_pend;
  endsequence
  a_pin_level_low: assert property (!alert_pin_a_n && !alert_pin_b_n)
    else $error("alert pin value not low");
  a_alert_disabled: assert property (!cfg3[0] |=> !alert_pin_a_oe)
    else $error("alert driven while disabled");
  a_alert_b_disabled: assert property (!cfg4[0] |=> !alert_pin_b_oe)
    else $error("alternate alert driven while disabled");
  a_alert_on_flag: assert property (
    cfg3[0] && |(pri_pend & ~m1[6:0]) |=> alert_pin_a_oe)
    else $error("alert missing for unmasked flag");
  a_status_sticky: assert property (s_pri_read |=>
    &(reg_rdata[6:0] | ~$past(pri_pend)))
    else $error("status flag lost before read");
  a_summary_bit: assert property (s_summary_read |=> reg_rdata[7])
    else $error("summary bit clear with secondary flag");
  a_unmapped_zero: assert property (reg_req.read && !(reg_req.addr inside
    {8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h7d}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_boost_running: assert property (
    (fan_full_duty & ~$past(fan_running)) == '0)
    else $error("boost on stopped fan");
  a_boost_cause: assert property (fan_full_duty != '0 |->
    $past(thermal_event_pin) && $past(cfg3[2]))
    else $error("boost without thermal pin");
  a_thermal_enable: assert property (thermal_event_pin |-> cfg3[1])
    else $error("thermal event while disabled");
endmodule : lsa_alert_unit_sva

bind lsa_alert_unit lsa_alert_unit_sva #(.fan_count(fan_count))
  i_lsa_alert_unit_sva (.clock(clock), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .result_valid(result_valid),
  .result_high(result_high), .result_low(result_low),
  .alert_pin_a_n(alert_pin_a_n), .alert_pin_a_oe(alert_pin_a_oe),
  .alert_pin_b_n(alert_pin_b_n), .alert_pin_b_oe(alert_pin_b_oe),
  .fan_running(fan_running), .fan_full_duty(fan_full_duty),
  .thermal_event_pin(thermal_event_pin));

// ==== test/lsa_host_model.sv ====
// Host model: issues single-byte register requests one at a time
`timescale 1ns/10ps
module lsa_host_model (
  input  wire logic             clock,
  output lsa_pkg::lsa_reg_req_t reg_req
);
  initial reg_req = '0;
  // Release with strobes cleared and address and data inverted so stale values never look fresh
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [7:0] wdata);
    @(negedge clock);
    reg_req <= '{write: wr, read: !wr, addr: addr, wdata: wdata};
    @(negedge clock);
    reg_req <= '{write: 1'b0, read: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask : xfer
endmodule : lsa_host_model

// ==== test/test_limit_status_alert_unit.sv ====
// Self-checking bench for the limit status alert unit
`timescale 1ns/10ps
module test_limit_status_alert_unit;
  logic                  clock = 0, rst_n = 0, rd_taken = 0;
  lsa_pkg::lsa_reg_req_t reg_req;
  lsa_pkg::lsa_sources_t vld = '0, hi = '0, lo = '0;
  logic                  thermal_event_pin_lim = 0, id_sel = 0, pin_a = 1, pin_b = 1;
  logic [5:0]            vid = '0;
  logic [3:0]            run = '0, full;
  logic [7:0]            rdata, m;
  logic                  oe_a, oe_b, n_a, n_b, tev;
  logic [7:0]            exp_q[$];
  int                    errors = 0, tests_run = 0, cycles = 0;
  always #12.5 clock = ~clock;
  lsa_alert_unit i_lsa_alert_unit (.clock(clock), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata(rdata), .result_valid(vld),
    .result_high(hi), .result_low(lo), .thermal_limit_exceeded(thermal_event_pin_lim),
    .voltage_id_input(vid), .id_change_select(id_sel),
    .thermal_pin_a_in(pin_a), .thermal_pin_b_in(pin_b),
    .alert_pin_a_n(n_a), .alert_pin_a_oe(oe_a), .alert_pin_b_n(n_b),
    .alert_pin_b_oe(oe_b), .fan_running(run), .fan_full_duty(full),
    .thermal_event_pin(tev));
  lsa_host_model i_lsa_host_model (.clock(clock), .reg_req(reg_req));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Read data lands one cycle after the strobe is taken
  always @(posedge clock) rd_taken <= reg_req.read;
  always @(negedge clock) if (rd_taken) check(rdata, exp_q.pop_front());
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_lsa_host_model.xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_lsa_host_model.xfer(1'b1, a, d);
  endtask : wr
  task automatic waitc(input int n);
    repeat (n) @(negedge clock);
  endtask : waitc
  // One comparison result; out of limit via a random high or low side
  task automatic evt(input bit sec, input int b, input bit out);
    int  i;
    bit  h;
    i = sec ? b : b + 8;
    h = 1'($urandom);
    @(negedge clock);
    vld[i] <= 1'b1;
    hi[i]  <= out & h;
    lo[i]  <= out & !h;
    @(negedge clock);
    vld[i] <= 1'b0;
  endtask : evt
  task automatic tally_and_finish;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] addrs[7];
    addrs = '{8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h7d, 8'h50};
    void'($urandom(31));
    waitc(10);
    rst_n <= 1'b1;
    foreach (addrs[k]) rd(addrs[k], 8'h00);
    check({n_a, n_b}, 8'h00);
    wr(8'h41, 8'hff);
    rd(8'h41, 8'h00);
    for (int k = 8'h74; k <= 8'h75; k++) begin
      m = 8'($urandom);
      wr(8'(k), m);
      rd(8'(k), m);
      wr(8'(k), 8'h00);
    end
    wr(8'h78, 8'h01);
    for (int b = 0; b < 7; b++) begin
      evt(0, b, 1);
      waitc(2);
      check(oe_a, 8'h01);
      evt(0, b, 0);
      waitc(3);
      check(oe_a, 8'h01);
      rd(8'h41, 8'(1 << b));
      rd(8'h41, 8'h00);
      waitc(2);
      check(oe_a, 8'h00);
    end
    for (int b = 0; b < 8; b++) begin
      evt(1, b, 1);
      evt(1, b, 0);
      waitc(2);
      check(oe_a, 8'h01);
      rd(8'h41, 8'h80);
      rd(8'h42, 8'(1 << b));
      rd(8'h42, 8'h00);
      rd(8'h41, 8'h00);
    end
    wr(8'h74, 8'h88);
    evt(0, 3, 1);
    evt(1, 2, 1);
    waitc(3);
    check(oe_a, 8'h00);
    evt(0, 3, 0);
    evt(1, 2, 0);
    rd(8'h42, 8'h04);
    rd(8'h41, 8'h08);
    rd(8'h41, 8'h00);
    wr(8'h74, 8'h00);
    // Service order: read, mask, handle, poll until clear, unmask
    evt(0, 5, 1);
    waitc(2);
    check(oe_a, 8'h01);
    rd(8'h41, 8'h20);
    wr(8'h74, 8'h20);
    waitc(2);
    check(oe_a, 8'h00);
    rd(8'h41, 8'h20);
    evt(0, 5, 0);
    rd(8'h41, 8'h20);
    rd(8'h41, 8'h00);
    wr(8'h74, 8'h00);
    waitc(2);
    check(oe_a, 8'h00);
    wr(8'h75, 8'h01);
    id_sel = 1'b1;
    waitc(2);
    vid = 6'h2a;
    waitc(3);
    check(oe_a, 8'h00);
    rd(8'h42, 8'h01);
    rd(8'h42, 8'h00);
    wr(8'h75, 8'h00);
    wr(8'h78, 8'h00);
    wr(8'h7d, 8'h01);
    evt(0, 6, 1);
    evt(0, 6, 0);
    waitc(2);
    check({oe_a, oe_b}, 8'h01);
    rd(8'h41, 8'h40);
    waitc(2);
    check(oe_b, 8'h00);
    wr(8'h7d, 8'h00);
    wr(8'h78, 8'h06);
    run = 4'($urandom) | 4'h1;
    pin_a = 1'b0;
    thermal_event_pin_lim = 1'b1;
    waitc(8);
    check(full, run);
    check(tev, 8'h01);
    thermal_event_pin_lim = 1'b0;
    rd(8'h42, 8'h20);
    rd(8'h42, 8'h00);
    pin_a = 1'b1;
    waitc(8);
    check({tev, full}, 8'h00);
    wr(8'h7d, 8'h02);
    pin_a = 1'b0;
    waitc(8);
    check({tev, full}, 8'h00);
    pin_a = 1'b1;
    pin_b = 1'b0;
    waitc(8);
    check({tev, full}, {3'h0, 1'b1, run});
    run = 4'h0;
    waitc(3);
    check(full, 8'h00);
    tally_and_finish();
  end
endmodule : test_limit_status_alert_unit
